// ==== src/tkc_cfg.svh ====
`ifndef TKC_CFG_SVH
`define TKC_CFG_SVH

// Register byte offsets
`define TKC_OFF_CTRL      8'h00
`define TKC_OFF_TICKCTRL  8'h04
`define TKC_OFF_STATUS    8'h08
`define TKC_OFF_MASK      8'h0C
`define TKC_OFF_CNT       8'h10
`define TKC_OFF_PER       8'h14
`define TKC_OFF_CMP       8'h18
`define TKC_OFF_CRYSTAL_CALIBRATION_VALUE     8'h1C

// Control fields
`define TKC_CTRL_CEN      0
`define TKC_CTRL_CORR     1
`define TKC_CTRL_PSEL_LO  2
`define TKC_CTRL_CSEL_LO  6
`define TKC_TICK_EN       0
`define TKC_TICK_SEL_LO   1

// Status and mask bit positions
`define TKC_ST_OVF        0
`define TKC_ST_CMP        1
`define TKC_ST_TICK       2

// Calibration fields
`define TKC_CAL_SIGN      7

// Reset values
`define TKC_RST_PER       16'hFFFF
`define TKC_RST_CMP       16'h0000

// Correction interval in timekeeping cycles
`define TKC_CORR_INTERVAL 20'hF4240
`define TKC_OSC_DIV_LAST  5'h1F
// Level events tap prescaler bits for divisions 64 to 8192
`define TKC_EVT_LO        5
`define TKC_EVT_HI        12

`endif

// ==== src/tkc_pkg.sv ====
package tkc_pkg;

  // Timekeeping reference source
  typedef enum logic [1:0] {
    TKC_SRC_XTAL   = 2'h0,
    TKC_SRC_EXTCLK = 2'h1,
    TKC_SRC_OSC    = 2'h2,
    TKC_SRC_OSC32  = 2'h3
  } tkc_clksel_e;

  // Direction of one crystal correction step
  typedef enum logic [2:0] {
    TKC_STEP_HOLD = 3'b001,
    TKC_STEP_ONE  = 3'b010,
    TKC_STEP_TWO  = 3'b100
  } tkc_step_e;

endpackage : tkc_pkg

// ==== src/tkc_timekeeper.sv ====
// The register addresses and register access over Wishbone were left to the implementer.
`timescale 1ns/1ps
`include "tkc_cfg.svh"
module tkc_timekeeper
  import tkc_pkg::*;
#(
  parameter int unsigned CNT_W   = 16,
  parameter int unsigned PRESC_W = 15
) (
  input  wire logic        i_clk,
  input  wire logic        i_resetn,
  input  wire logic        i_wb_cyc,
  input  wire logic        i_wb_stb,
  input  wire logic        i_wb_we,
  input  wire logic [7:0]  i_wb_adr,
  input  wire logic [3:0]  i_wb_sel,
  input  wire logic [31:0] i_wb_dat,
  output logic      [31:0] o_wb_dat,
  output logic             o_wb_ack,
  input  wire logic        i_xtal_clk,
  input  wire logic        i_ext_clk,
  input  wire logic        i_osc_clk,
  output logic             o_irq,
  output logic             o_ovf_evt,
  output logic             o_cmp_evt,
  output logic      [7:0]  o_tick_lvl,
  output logic             o_tick_out
);

  ////////////////////////////////////////////////////////////////////////////
  // Reset release
  logic rst_meta_q;
  logic rst_n_q;

  // Two-stage release of the asynchronous reset
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      rst_meta_q <= 1'b0;
      rst_n_q    <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n_q    <= rst_meta_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register storage
  logic [7:0]         ctrl_q;
  logic [4:0]         tickctrl_q;
  logic [2:0]         status_q;
  logic [2:0]         mask_q;
  logic [CNT_W-1:0]   cnt_q;
  logic [CNT_W-1:0]   per_q;
  logic [CNT_W-1:0]   cmp_q;
  logic [7:0]         crystal_calibration_value_q;
  logic               ack_q;
  logic [31:0]        rdat_q;
  logic               acc_go;
  logic               wr_go;
  logic [31:0]        wmask;
  logic               cen;
  logic               ten;
  logic               corr_en;
  logic [3:0]         psel;
  tkc_clksel_e        csel;
  logic [3:0]         tsel;

  assign acc_go  = i_wb_cyc && i_wb_stb && !ack_q;
  assign wr_go   = acc_go && i_wb_we;
  assign wmask   = {{8{i_wb_sel[3]}}, {8{i_wb_sel[2]}}, {8{i_wb_sel[1]}}, {8{i_wb_sel[0]}}};
  assign cen     = ctrl_q[`TKC_CTRL_CEN];
  assign corr_en = ctrl_q[`TKC_CTRL_CORR];
  assign psel    = ctrl_q[`TKC_CTRL_PSEL_LO +: 4];
  assign csel    = tkc_clksel_e'(ctrl_q[`TKC_CTRL_CSEL_LO +: 2]);
  assign ten     = tickctrl_q[`TKC_TICK_EN];
  assign tsel    = tickctrl_q[`TKC_TICK_SEL_LO +: 4];

  // Byte-lane merge of write data into an old value
  function automatic logic [31:0] tkc_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                            input logic [31:0] lanes);
    tkc_merge = (old_v & ~lanes) | (new_v & lanes);
  endfunction : tkc_merge

  ////////////////////////////////////////////////////////////////////////////
  // Reference source selection
  logic        xtal_q;
  logic        ext_q;
  logic        osc_q;
  logic [4:0]  oscdiv_q;
  logic        xtal_rise;
  logic        ext_rise;
  logic        osc_rise;
  logic        osc32_rise;
  logic        src_tick;

  assign xtal_rise  = i_xtal_clk && !xtal_q;
  assign ext_rise   = i_ext_clk && !ext_q;
  assign osc_rise   = i_osc_clk && !osc_q;
  assign osc32_rise = osc_rise && (oscdiv_q == `TKC_OSC_DIV_LAST);

  // Edge history and oscillator divide-by-32
  always_ff @(posedge i_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      xtal_q   <= 1'b0;
      ext_q    <= 1'b0;
      osc_q    <= 1'b0;
      oscdiv_q <= 5'h00;
    end else begin
      xtal_q <= i_xtal_clk;
      ext_q  <= i_ext_clk;
      osc_q  <= i_osc_clk;
      if (osc_rise) begin
        oscdiv_q <= oscdiv_q + 5'h01;
      end
    end
  end

  // One-cycle enable per timekeeping clock period
  always_comb begin
    case (csel)
      TKC_SRC_XTAL:   src_tick = xtal_rise;
      TKC_SRC_EXTCLK: src_tick = ext_rise;
      TKC_SRC_OSC:    src_tick = osc_rise;
      TKC_SRC_OSC32:  src_tick = osc32_rise;
      default:        src_tick = 1'b0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Crystal correction
  logic        corr_run_q;
  logic        corr_ok;
  logic [19:0] ivl_q;
  logic [19:0] acc_q;
  logic [20:0] acc_sum;
  logic        corr_pulse;

  assign corr_ok    = corr_en && (csel == TKC_SRC_XTAL);
  assign acc_sum    = {1'b0, acc_q} + {14'h0000, crystal_calibration_value_q[6:0]};
  assign corr_pulse = corr_run_q && src_tick && (acc_sum >= {1'b0, `TKC_CORR_INTERVAL});

  // Interval and spreading accumulator
  always_ff @(posedge i_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      corr_run_q <= 1'b0;
      ivl_q      <= 20'h00000;
      acc_q      <= 20'h00000;
    end else if (!corr_run_q) begin
      if (corr_ok) begin
        corr_run_q <= 1'b1;
        ivl_q      <= 20'h00000;
        acc_q      <= 20'h00000;
      end
    end else if (src_tick) begin
      if (ivl_q == `TKC_CORR_INTERVAL - 20'h00001) begin
        ivl_q <= 20'h00000;
        acc_q <= 20'h00000;
        if (!corr_ok) begin
          corr_run_q <= 1'b0;
        end
      end else begin
        ivl_q <= ivl_q + 20'h00001;
        acc_q <= corr_pulse ? 20'(acc_sum - {1'b0, `TKC_CORR_INTERVAL}) : acc_sum[19:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Shared prescaler
  logic [PRESC_W-1:0] presc_q;
  logic [PRESC_W-1:0] presc_nx;
  logic [PRESC_W-1:0] pmask;
  logic [PRESC_W:0]   pone;
  tkc_step_e          step;
  logic               run;
  logic               cnt_tick;
  logic               tick_evt;

  assign run  = cen || ten;
  assign pone = (PRESC_W+1)'(1) << psel;
  assign pmask = pone[PRESC_W-1:0] - PRESC_W'(1);

  // Correction skips or inserts a prescaler count
  always_comb begin
    step = TKC_STEP_ONE;
    if (corr_pulse) begin
      step = crystal_calibration_value_q[`TKC_CAL_SIGN] ? TKC_STEP_TWO : TKC_STEP_HOLD;
    end
    case (step)
      TKC_STEP_HOLD: presc_nx = presc_q;
      TKC_STEP_ONE:  presc_nx = presc_q + PRESC_W'(1);
      TKC_STEP_TWO:  presc_nx = presc_q + PRESC_W'(2);
      default:       presc_nx = presc_q;
    endcase
  end

  // Counter enable when the masked prescaler bits wrap
  assign cnt_tick = run && src_tick && (step != TKC_STEP_HOLD) &&
                    ((psel == 4'h0) || ((presc_nx & pmask) < (presc_q & pmask)));
  // Tick event on rising edge of the selected prescaler bit
  assign tick_evt = ten && src_tick && (tsel != 4'h0) && (tsel != 4'hF) &&
                    presc_nx[tsel] && !presc_q[tsel];

  // Prescaler held at zero while both functions are off
  always_ff @(posedge i_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      presc_q <= '0;
    end else if (!run) begin
      presc_q <= '0;
    end else if (src_tick) begin
      presc_q <= presc_nx;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Counter
  logic wr_cnt;
  logic hit_per;
  logic hit_cmp;
  assign wr_cnt  = wr_go && (i_wb_adr == `TKC_OFF_CNT);
  assign hit_per = cen && cnt_tick && (cnt_q == per_q);
  assign hit_cmp = cen && cnt_tick && (cnt_q == cmp_q);

  // Counting runs whatever the system sleep state
  always_ff @(posedge i_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      cnt_q <= '0;
    end else if (wr_cnt) begin
      cnt_q <= CNT_W'(tkc_merge(32'(cnt_q), i_wb_dat, wmask));
    end else if (hit_per) begin
      cnt_q <= '0;
    end else if (cen && cnt_tick) begin
      cnt_q <= cnt_q + CNT_W'(1);
    end
  end

  // Event pulses and level events
  always_ff @(posedge i_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      o_ovf_evt  <= 1'b0;
      o_cmp_evt  <= 1'b0;
      o_tick_lvl <= 8'h00;
      o_tick_out <= 1'b0;
    end else begin
      o_ovf_evt  <= hit_per;
      o_cmp_evt  <= hit_cmp;
      o_tick_lvl <= ten ? presc_q[`TKC_EVT_HI:`TKC_EVT_LO] : 8'h00;
      o_tick_out <= ten && (tsel != 4'h0) && (tsel != 4'hF) && presc_q[tsel];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status flags: set wins over write-one-to-clear
  logic [2:0] st_set;
  logic [2:0] st_clr;
  assign st_set = {tick_evt, hit_cmp, hit_per};
  assign st_clr = (wr_go && (i_wb_adr == `TKC_OFF_STATUS) && i_wb_sel[0]) ? i_wb_dat[2:0] : 3'h0;

  always_ff @(posedge i_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      status_q <= 3'h0;
    end else begin
      status_q <= (status_q & ~st_clr) | st_set;
    end
  end

  // Level interrupt, also the wake request
  assign o_irq = |(status_q & mask_q);

  ////////////////////////////////////////////////////////////////////////////
  // Wishbone slave: writes
  always_ff @(posedge i_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      ctrl_q     <= 8'h00;
      tickctrl_q <= 5'h00;
      mask_q     <= 3'h0;
      per_q      <= `TKC_RST_PER;
      cmp_q      <= `TKC_RST_CMP;
      crystal_calibration_value_q    <= 8'h00;
    end else if (wr_go) begin
      case (i_wb_adr)
        `TKC_OFF_CTRL:     ctrl_q     <= 8'(tkc_merge(32'(ctrl_q), i_wb_dat, wmask));
        `TKC_OFF_TICKCTRL: tickctrl_q <= 5'(tkc_merge(32'(tickctrl_q), i_wb_dat, wmask));
        `TKC_OFF_MASK:     mask_q     <= 3'(tkc_merge(32'(mask_q), i_wb_dat, wmask));
        `TKC_OFF_PER:      per_q      <= CNT_W'(tkc_merge(32'(per_q), i_wb_dat, wmask));
        `TKC_OFF_CMP:      cmp_q      <= CNT_W'(tkc_merge(32'(cmp_q), i_wb_dat, wmask));
        `TKC_OFF_CRYSTAL_CALIBRATION_VALUE:    crystal_calibration_value_q    <= 8'(tkc_merge(32'(crystal_calibration_value_q), i_wb_dat, wmask));
        default:           ctrl_q     <= ctrl_q;
      endcase
    end
  end

  // Wishbone slave: acknowledge and registered read data
  always_ff @(posedge i_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      ack_q  <= 1'b0;
      rdat_q <= 32'h00000000;
    end else begin
      ack_q <= acc_go;
      if (acc_go && !i_wb_we) begin
        case (i_wb_adr)
          `TKC_OFF_CTRL:     rdat_q <= {24'h000000, ctrl_q};
          `TKC_OFF_TICKCTRL: rdat_q <= {27'h0000000, tickctrl_q};
          `TKC_OFF_STATUS:   rdat_q <= {29'h00000000, status_q};
          `TKC_OFF_MASK:     rdat_q <= {29'h00000000, mask_q};
          `TKC_OFF_CNT:      rdat_q <= 32'(cnt_q);
          `TKC_OFF_PER:      rdat_q <= 32'(per_q);
          `TKC_OFF_CMP:      rdat_q <= 32'(cmp_q);
          `TKC_OFF_CRYSTAL_CALIBRATION_VALUE:    rdat_q <= {24'h000000, crystal_calibration_value_q};
          default:           rdat_q <= 32'h00000000;
        endcase
      end
    end
  end

  assign o_wb_ack = ack_q;
  assign o_wb_dat = rdat_q;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  default clocking tkc_cb @(posedge i_clk); endclocking
  default disable iff (!rst_n_q);

  ovf_wraps_a: assert property (hit_per && !wr_cnt |=> cnt_q == '0 && status_q[`TKC_ST_OVF] && o_ovf_evt)
    else $error("overflow did not wrap counter and set flag");
  cmp_flag_a: assert property (hit_cmp |=> status_q[`TKC_ST_CMP] && o_cmp_evt)
    else $error("compare equality did not raise flag");
  cnt_step_a: assert property (cen && cnt_tick && !hit_per && !wr_cnt |=> cnt_q == $past(cnt_q) + CNT_W'(1))
    else $error("counter did not advance by one");
  cnt_hold_a: assert property (!cen && !wr_cnt |=> $stable(cnt_q))
    else $error("counter moved while disabled");
  presc_off_a: assert property (!cen && !ten |=> presc_q == '0)
    else $error("prescaler ran with both functions off");
  tick_flag_a: assert property (tick_evt |=> status_q[`TKC_ST_TICK])
    else $error("tick event lost");
  flag_sticky_a: assert property (status_q[`TKC_ST_OVF] && !st_clr[`TKC_ST_OVF] |=> status_q[`TKC_ST_OVF])
    else $error("overflow flag dropped without clear");
  irq_mask_a: assert property (status_q[`TKC_ST_CMP] && mask_q[`TKC_ST_CMP] |-> o_irq)
    else $error("unmasked flag gave no interrupt");
  corr_end_a: assert property ($fell(corr_run_q) |-> $past(ivl_q) == `TKC_CORR_INTERVAL - 20'h00001)
    else $error("correction stopped inside an interval");
  corr_src_a: assert property (corr_pulse |-> $past(corr_ok) || corr_ok || corr_run_q)
    else $error("correction outside crystal mode");
  ack_pulse_a: assert property (acc_go |=> o_wb_ack ##1 !o_wb_ack)
    else $error("bus acknowledge not a single cycle");
  ovf_seen_c:  cover property (hit_per);
  cmp_seen_c:  cover property (hit_cmp);
  tick_seen_c: cover property (tick_evt ##[1:8] status_q[`TKC_ST_TICK]);
  corr_seen_c: cover property (corr_pulse);

endmodule : tkc_timekeeper

// ==== tb/testbench.sv ====
`timescale 1ns/1ps
`include "tkc_cfg.svh"
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin fail_count++; \
  $display("mismatch t=%0t got=%0h exp=%0h", $time, (g), (e)); end end
module testbench
  import tkc_pkg::*;
;
  logic        i_clk, i_resetn, i_wb_cyc, i_wb_stb, i_wb_we;
  logic [7:0]  i_wb_adr;
  logic [3:0]  i_wb_sel;
  logic [31:0] i_wb_dat, o_wb_dat;
  logic        o_wb_ack, o_irq, o_ovf_evt, o_cmp_evt, o_tick_out;
  logic        i_xtal_clk, i_ext_clk, i_osc_clk;
  logic [7:0]  o_tick_lvl;
  logic [63:0] exp_q[$];
  logic [63:0] note;
  logic [1:0]  ref_div;
  logic [2:0]  ext_div;
  int          fail_count, checks_done, seed, n;
  logic [31:0] rnd;

  tkc_timekeeper dut (.i_clk(i_clk), .i_resetn(i_resetn), .i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb),
    .i_wb_we(i_wb_we), .i_wb_adr(i_wb_adr), .i_wb_sel(i_wb_sel), .i_wb_dat(i_wb_dat),
    .o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack), .i_xtal_clk(i_xtal_clk), .i_ext_clk(i_ext_clk),
    .i_osc_clk(i_osc_clk), .o_irq(o_irq), .o_ovf_evt(o_ovf_evt), .o_cmp_evt(o_cmp_evt),
    .o_tick_lvl(o_tick_lvl), .o_tick_out(o_tick_out));

  ////////////////////////////////////////////////////////////////////////////
  // Clock, 4 ns period
  always #2 i_clk = ~i_clk;

  // Reference sources: crystal and oscillator 4 clocks, external 6 clocks
  always @(posedge i_clk) begin
    ref_div    <= ref_div + 2'h1;
    ext_div    <= (ext_div == 3'h5) ? 3'h0 : ext_div + 3'h1;
    i_xtal_clk <= ref_div[1];
    i_osc_clk  <= ref_div[1];
    i_ext_clk  <= (ext_div > 3'h2);
  end

  // Read data checker: oldest note against each acknowledged answer
  always @(posedge i_clk) begin
    if (o_wb_ack === 1'b1 && exp_q.size() > 0) begin
      note = exp_q.pop_front();
      if (note[63:32] != 32'h0)
        `CHK(o_wb_dat & note[63:32], note[31:0])
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Classic single Wishbone cycle; waits for ack, then idles one cycle
  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat,
                    input logic [31:0] msk, input logic [31:0] ev);
    int t;
    t = 0;
    exp_q.push_back({msk, ev});
    @(posedge i_clk);
    i_wb_cyc <= 1'b1;
    i_wb_stb <= 1'b1;
    i_wb_we  <= we;
    i_wb_adr <= adr;
    i_wb_sel <= 4'hF;
    i_wb_dat <= dat;
    do begin
      @(posedge i_clk);
      t++;
    end while (o_wb_ack !== 1'b1);
    `CHK(t, 2)
    i_wb_cyc <= 1'b0;
    i_wb_stb <= 1'b0;
    i_wb_we  <= 1'b0;
    @(posedge i_clk);
  endtask : wb

  task automatic wr(input logic [7:0] adr, input logic [31:0] dat);
    wb(1'b1, adr, dat, 32'h0, 32'h0);
  endtask : wr

  task automatic rd(input logic [7:0] adr, input logic [31:0] msk, input logic [31:0] ev);
    wb(1'b0, adr, 32'h0, msk, ev);
  endtask : rd

  // Wait for a pulse on the given event output within a bound
  task automatic wait_evt(input bit ovf, input int lim, output int clks);
    clks = 0;
    do begin
      @(posedge i_clk);
      clks++;
    end while (((ovf ? o_ovf_evt : o_cmp_evt) !== 1'b1) && clks < lim);
  endtask : wait_evt

  // Clocks between two changes of the tick output or its lowest level tap
  task automatic toggle_gap(input bit lvl, output int clks);
    logic v;
    for (int k = 0; k < 3; k++) begin
      clks = 0;
      v    = lvl ? o_tick_lvl[0] : o_tick_out;
      do begin
        @(posedge i_clk);
        clks++;
      end while ((lvl ? o_tick_lvl[0] : o_tick_out) === v && clks < 2000);
    end
  endtask : toggle_gap

  task automatic wrap_up;
    $display("checks_done=%0d fail_count=%0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : wrap_up

  ////////////////////////////////////////////////////////////////////////////
  // Watchdog: the correction wraps alone take about 33000 clocks
  initial begin
    #300000;
    fail_count++;
    wrap_up();
  end

  // Main sequence
  initial begin
    {i_clk, i_resetn, i_wb_cyc, i_wb_stb, i_wb_we} = 5'h0;
    {i_wb_adr, i_wb_sel, i_wb_dat} = 44'h0;
    {i_xtal_clk, i_ext_clk, i_osc_clk, ref_div, ext_div} = 8'h0;
    fail_count = 0;
    checks_done = 0;
    seed = 65067;
    repeat (8) @(posedge i_clk);
    i_resetn <= 1'b1;
    repeat (3) @(posedge i_clk);
    // Reset values and an unmapped place
    rd(`TKC_OFF_PER, 32'hFFFFFFFF, {16'h0, `TKC_RST_PER});
    rd(`TKC_OFF_CMP, 32'hFFFFFFFF, {16'h0, `TKC_RST_CMP});
    wr(8'h20, 32'hFFFFFFFF);
    rd(8'h20, 32'hFFFFFFFF, 32'h0);
    // Random values through the 16-bit registers, upper bits read zero
    for (int i = 0; i < 4; i++) begin
      rnd = $random(seed);
      wr(`TKC_OFF_CNT + 8'(4 * (i % 3)), rnd);
      rd(`TKC_OFF_CNT + 8'(4 * (i % 3)), 32'hFFFFFFFF, rnd & 32'hFFFF);
    end
    // Compare then overflow, sticky flags and masking
    wr(`TKC_OFF_MASK, 32'h0);
    wr(`TKC_OFF_CNT, 32'h0);
    wr(`TKC_OFF_PER, 32'h5);
    wr(`TKC_OFF_CMP, 32'h2);
    wr(`TKC_OFF_STATUS, 32'h7);
    wr(`TKC_OFF_CTRL, 32'h1);
    wait_evt(1'b0, 400, n);
    `CHK(o_cmp_evt, 1'b1)
    wait_evt(1'b1, 400, n);
    `CHK(o_ovf_evt, 1'b1)
    wr(`TKC_OFF_CTRL, 32'h0);
    rd(`TKC_OFF_STATUS, 32'h3, 32'h3);
    `CHK(o_irq, 1'b0)
    wr(`TKC_OFF_MASK, 32'h1);
    `CHK(o_irq, 1'b1)
    wr(`TKC_OFF_STATUS, 32'h1);
    rd(`TKC_OFF_STATUS, 32'h3, 32'h2);
    `CHK(o_irq, 1'b0)
    wr(`TKC_OFF_MASK, 32'h2);
    `CHK(o_irq, 1'b1)
    wr(`TKC_OFF_STATUS, 32'h7);
    // Overflow spacing for each source, prescale 0 to 3: (PER+1) << n ref periods
    wr(`TKC_OFF_PER, 32'h3);
    for (int s = 0; s < 4; s++) begin
      wr(`TKC_OFF_CTRL, (s << `TKC_CTRL_CSEL_LO) | (s << `TKC_CTRL_PSEL_LO) | 1);
      wait_evt(1'b1, 10000, n);
      wait_evt(1'b1, 10000, n);
      wait_evt(1'b1, 10000, n);
      `CHK(n, (s == 3 ? 128 : (s == 1 ? 6 : 4)) * (4 << s))
    end
    wr(`TKC_OFF_CTRL, 32'h0);
    // Tick timer alone: half period 2^s ref periods, flag and interrupt
    wr(`TKC_OFF_MASK, 32'h4);
    for (int s = 1; s < 4; s++) begin
      wr(`TKC_OFF_TICKCTRL, (s << `TKC_TICK_SEL_LO) | 1);
      toggle_gap(1'b0, n);
      `CHK(n, 4 << s)
    end
    rd(`TKC_OFF_STATUS, 32'h4, 32'h4);
    `CHK(o_irq, 1'b1)
    // Lowest level tap: divide by 64, so 32 ref periods a level
    toggle_gap(1'b1, n);
    `CHK(n, 128)
    wr(`TKC_OFF_TICKCTRL, 32'h0);
    repeat (4) @(posedge i_clk);
    `CHK(o_tick_lvl, 8'h0)
    wr(`TKC_OFF_STATUS, 32'h7);
    `CHK(o_irq, 1'b0)
    // Correction dropping counts: first held tick near tick 7875, inside the second wrap
    wr(`TKC_OFF_CNT, 32'h0);
    wr(`TKC_OFF_PER, 32'hFFF);
    wr(`TKC_OFF_CRYSTAL_CALIBRATION_VALUE, 32'h7F);
    wr(`TKC_OFF_CTRL, 32'h3);
    wait_evt(1'b1, 20000, n);
    wait_evt(1'b1, 20000, n);
    `CHK(n, 4097 * 4)
    wr(`TKC_OFF_CTRL, 32'h0);
    repeat (4) @(posedge i_clk);
    wrap_up();
  end
endmodule : testbench
